// ---- hdl/floppy_control_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef FLOPPY_CONTROL_MAP_SVH
`define FLOPPY_CONTROL_MAP_SVH

`define REG_COMMAND     8'h00
`define REG_CONFIG      8'h04
`define REG_RESULT      8'h08
`define REG_ID_FIELD    8'h0c
`define REG_DRIVE       8'h10
`define REG_STATE       8'h14

`define CMD_OP_LSB      0
`define CMD_UNIT_LSB    4
`define CMD_TARGET_LSB  8
`define CFG_STEP_LSB    0
`define CFG_NODMA_BIT   4
`define RES_PCN_LSB     8
`define RES_MA_BIT      16
`define STATE_BUSY_BIT  0
`define STATE_SEEK_LSB  4

`define CFG_STEP_RESET  4'h0
`define IC_NORMAL       2'b00
`define IC_ABNORMAL     2'b01
`define IC_INVALID      2'b10

`define CLK_MHZ         100
`define STEP_UNIT_US    1000
`define STEP_PULSE_US   1
`define STEP_SLOTS      16
`define RECAL_MAX_STEPS 79

`endif

// ---- hdl/floppy_control_pkg.sv ----
// Types shared by the control command block
package floppy_control_pkg;

	typedef enum logic [3:0] {
		CMD_READ_ID     = 4'h1,
		CMD_RECALIBRATE = 4'h2,
		CMD_SEEK        = 4'h3,
		CMD_SENSE_INT   = 4'h4,
		CMD_SENSE_DRIVE = 4'h5
	} command_e;

	typedef enum logic [3:0] {
		MOVE_IDLE  = 4'b0001,
		MOVE_CHECK = 4'b0010,
		MOVE_STEP  = 4'b0100,
		MOVE_GAP   = 4'b1000
	} move_state_e;

	typedef enum logic [1:0] {
		SCAN_IDLE   = 2'b01,
		SCAN_SEARCH = 2'b10
	} scan_state_e;

	typedef struct packed {
		logic [1:0] interrupt_cause_code;
		logic       seek_end_flag;
		logic       equipment_check_flag;
		logic       not_ready;
		logic       head;
		logic [1:0] unit;
	} status_zero_s;

	typedef struct packed {
		logic [7:0] cylinder;
		logic [7:0] head;
		logic [7:0] sector;
		logic [7:0] size;
	} id_field_s;

endpackage

// ---- hdl/floppy_control.sv ----
// Floppy positioning, head read and interrupt status command block
`timescale 1ns/1ps
`include "floppy_control_map.svh"

module floppy_control #(
	parameter int UNITS            = 4,
	parameter int STEP_UNIT_CYCLES = `STEP_UNIT_US * `CLK_MHZ
) (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [UNITS-1:0]              track_zero_sense,
	input  wire logic                          index_pulse_in,
	input  wire logic                          write_protect_in,
	input  wire logic                          low_power_state,
	input  wire logic                          id_valid,
	input  wire floppy_control_pkg::id_field_s id_field,
	input  wire logic                          result_phase_entered,
	input  wire logic                          data_byte_needed,
	output logic      [UNITS-1:0]              step_out,
	output logic      [UNITS-1:0]              direction_out,
	output logic                               floppy_irq_out,
	output logic                               transfer_request_out,
	output logic                               request_for_master
);

	localparam int PULSE = `STEP_PULSE_US * `CLK_MHZ;
	localparam int TW    = $clog2(STEP_UNIT_CYCLES * `STEP_SLOTS + 1);
	localparam int NPIN  = UNITS + 3;

	generate
		if (UNITS < 1 || UNITS > 4 || STEP_UNIT_CYCLES <= PULSE) begin : g_bad
			$error("floppy_control: unsupported parameters");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once stages two and three agree

	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	logic [NPIN-1:0] pin_s3;
	logic [NPIN-1:0] pin_f;

	assign pins = {low_power_state, write_protect_in, index_pulse_in,
		track_zero_sense};

	genvar p;
	generate
		for (p = 0; p < NPIN; p++) begin : g_sync
			// Three stages; stage one feeds stage two only
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					pin_s1[p] <= 1'b0;
					pin_s2[p] <= 1'b0;
					pin_s3[p] <= 1'b0;
					pin_f[p]  <= 1'b0;
				end else begin
					pin_s1[p] <= pins[p];
					pin_s2[p] <= pin_s1[p];
					pin_s3[p] <= pin_s2[p];
					if (pin_s2[p] == pin_s3[p]) begin
						pin_f[p] <= pin_s3[p];
					end
				end
			end
		end
	endgenerate

	logic [UNITS-1:0] tz;
	logic             index_f;
	logic             wp_f;
	logic             lp_f;
	logic             index_prev;
	logic             lp_prev;
	logic             index_rise;
	logic             lp_exit;

	assign tz         = pin_f[UNITS-1:0];
	assign index_f    = pin_f[UNITS];
	assign wp_f       = pin_f[UNITS+1];
	assign lp_f       = pin_f[UNITS+2];
	assign index_rise = index_f & ~index_prev;
	assign lp_exit    = lp_prev & ~lp_f;

	// Edge history for index and low-power exit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			index_prev <= 1'b0;
			lp_prev    <= 1'b0;
		end else begin
			index_prev <= index_f;
			lp_prev    <= lp_f;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state so read data comes from a flop

	logic        access;
	logic        cmd_go;
	logic        cfg_go;
	logic [3:0]  cmd_op;
	logic [1:0]  cmd_unit;
	logic [7:0]  cmd_target;
	logic        mapped;
	logic        next_pready;
	logic        next_pslverr;
	logic [31:0] next_prdata;

	assign access     = psel & penable & pready;
	assign cmd_go     = access & pwrite & (paddr == `REG_COMMAND);
	assign cfg_go     = access & pwrite & (paddr == `REG_CONFIG);
	assign cmd_op     = pwdata[`CMD_OP_LSB +: 4];
	assign cmd_unit   = pwdata[`CMD_UNIT_LSB +: 2];
	assign cmd_target = pwdata[`CMD_TARGET_LSB +: 8];

	////////////////////////////////////////////////////////////////////////
	// Per-drive positioning engines; each drive steps on its own

	logic [3:0]       step_interval_setting;
	logic             dma_disable_bit;
	logic [TW-1:0]    interval;
	logic [UNITS-1:0] pend;
	logic [UNITS-1:0] moving;
	logic [UNITS-1:0] ec_v;
	logic [UNITS-1:0] abn_v;
	logic [UNITS-1:0] sense_clr;
	logic [7:0]       pcn_v [UNITS];

	// Spacing slots shrink as the setting grows, as in the timing table
	assign interval = TW'((5'd16 - {1'b0, step_interval_setting})
		* STEP_UNIT_CYCLES);

	genvar g;
	generate
		for (g = 0; g < UNITS; g++) begin : g_drive
			floppy_control_pkg::move_state_e state;
			floppy_control_pkg::move_state_e next_state;
			logic [7:0]    present_cylinder;
			logic [7:0]    next_present_cylinder;
			logic [7:0]    target_cylinder;
			logic [7:0]    next_target_cylinder;
			logic          recal;
			logic          next_recal;
			logic [6:0]    steps;
			logic [6:0]    next_steps;
			logic [TW-1:0] timer;
			logic [TW-1:0] next_timer;
			logic          pending;
			logic          next_pending;
			logic          ec;
			logic          next_ec;
			logic          abn;
			logic          next_abn;
			logic          step;
			logic          next_step;
			logic          dir;
			logic          next_dir;
			logic          start;

			// Busy drive refuses a new start until its status is sensed
			assign start = cmd_go && cmd_unit == g && !pending
				&& state == floppy_control_pkg::MOVE_IDLE;

			// Next-state logic for one drive's stepper
			always_comb begin
				next_state            = state;
				next_present_cylinder = present_cylinder;
				next_target_cylinder  = target_cylinder;
				next_recal            = recal;
				next_steps            = steps;
				next_timer            = timer;
				next_pending          = pending & ~sense_clr[g];
				next_ec               = ec;
				next_abn              = abn;
				next_step             = step;
				next_dir              = dir;
				unique case (state)
					floppy_control_pkg::MOVE_IDLE: begin
						if (start && cmd_op == floppy_control_pkg::CMD_RECALIBRATE) begin
							next_present_cylinder = 8'h00;
							next_recal            = 1'b1;
							next_steps            = 7'h00;
							next_state            = floppy_control_pkg::MOVE_CHECK;
						end else if (start && cmd_op == floppy_control_pkg::CMD_SEEK) begin
							next_target_cylinder = cmd_target;
							next_recal           = 1'b0;
							next_state           = floppy_control_pkg::MOVE_CHECK;
						end
					end
					floppy_control_pkg::MOVE_CHECK: begin
						if (recal ? tz[g]
							: present_cylinder == target_cylinder) begin
							next_pending = 1'b1;
							next_ec      = 1'b0;
							next_abn     = 1'b0;
							next_state   = floppy_control_pkg::MOVE_IDLE;
						end else if (recal && steps == 7'(`RECAL_MAX_STEPS)) begin
							next_pending = 1'b1;
							next_ec      = 1'b1;
							next_abn     = 1'b1;
							next_state   = floppy_control_pkg::MOVE_IDLE;
						end else begin
							next_step  = 1'b1;
							next_timer = TW'(PULSE);
							next_steps = steps + 7'h01;
							next_state = floppy_control_pkg::MOVE_STEP;
							if (recal) begin
								next_dir = 1'b0;
							end else if (present_cylinder < target_cylinder) begin
								next_dir              = 1'b1;
								next_present_cylinder = present_cylinder + 8'h01;
							end else begin
								next_dir              = 1'b0;
								next_present_cylinder = present_cylinder - 8'h01;
							end
						end
					end
					floppy_control_pkg::MOVE_STEP: begin
						next_timer = timer - TW'(1);
						if (timer == TW'(1)) begin
							next_step  = 1'b0;
							next_timer = interval - TW'(PULSE);
							next_state = floppy_control_pkg::MOVE_GAP;
						end
					end
					floppy_control_pkg::MOVE_GAP: begin
						next_timer = timer - TW'(1);
						if (timer <= TW'(1)) begin
							next_state = floppy_control_pkg::MOVE_CHECK;
						end
					end
				endcase
				if (lp_exit) begin
					next_present_cylinder = 8'h00;
					next_pending          = 1'b0;
					next_ec               = 1'b0;
					next_abn              = 1'b0;
					next_step             = 1'b0;
					next_state            = floppy_control_pkg::MOVE_IDLE;
				end
			end

			// Stepper registers
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					state            <= floppy_control_pkg::MOVE_IDLE;
					present_cylinder <= 8'h00;
					target_cylinder  <= 8'h00;
					recal            <= 1'b0;
					steps            <= 7'h00;
					timer            <= '0;
					pending          <= 1'b0;
					ec               <= 1'b0;
					abn              <= 1'b0;
					step             <= 1'b0;
					dir              <= 1'b0;
				end else begin
					state            <= next_state;
					present_cylinder <= next_present_cylinder;
					target_cylinder  <= next_target_cylinder;
					recal            <= next_recal;
					steps            <= next_steps;
					timer            <= next_timer;
					pending          <= next_pending;
					ec               <= next_ec;
					abn              <= next_abn;
					step             <= next_step;
					dir              <= next_dir;
				end
			end

			assign step_out[g]      = step;
			assign direction_out[g] = dir;
			assign pend[g]          = pending;
			assign moving[g]        = state != floppy_control_pkg::MOVE_IDLE;
			assign ec_v[g]          = ec;
			assign abn_v[g]         = abn;
			assign pcn_v[g]         = present_cylinder;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Command interpreter: head read, interrupt status, drive status

	// Lowest pending drive is reported first
	function automatic logic [1:0] first_pending(input logic [UNITS-1:0] v);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = UNITS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 2'(i);
			end
		end
		return idx;
	endfunction

	logic [1:0] sel;
	logic       sense_go;

	assign sel      = first_pending(pend);
	assign sense_go = cmd_go && cmd_op == floppy_control_pkg::CMD_SENSE_INT;

	generate
		for (g = 0; g < UNITS; g++) begin : g_clr
			assign sense_clr[g] = sense_go && sel == g;
		end
	endgenerate

	floppy_control_pkg::scan_state_e scan;
	floppy_control_pkg::scan_state_e next_scan;
	floppy_control_pkg::status_zero_s st0_report;
	floppy_control_pkg::status_zero_s next_st0_report;
	floppy_control_pkg::status_zero_s scan_st0;
	floppy_control_pkg::status_zero_s next_scan_st0;
	floppy_control_pkg::id_field_s    id_capture;
	floppy_control_pkg::id_field_s    next_id_capture;
	logic [7:0] pcn_report;
	logic [7:0] next_pcn_report;
	logic       missing_address_mark_flag;
	logic       next_missing_address_mark_flag;
	logic [7:0] drive_status_report;
	logic [7:0] next_drive_status_report;
	logic       index_seen;
	logic       next_index_seen;
	logic [1:0] scan_unit;
	logic [1:0] next_scan_unit;
	logic       result_pending;
	logic       next_result_pending;
	logic [3:0] next_step_interval_setting;
	logic       next_dma_disable_bit;
	logic       next_irq;

	// Command decode and result formation
	always_comb begin
		next_scan                      = scan;
		next_st0_report                = st0_report;
		next_scan_st0                  = scan_st0;
		next_id_capture                = id_capture;
		next_pcn_report                = pcn_report;
		next_missing_address_mark_flag = missing_address_mark_flag;
		next_drive_status_report       = drive_status_report;
		next_index_seen                = index_seen;
		next_scan_unit                 = scan_unit;
		next_result_pending            = result_pending;
		next_step_interval_setting     = step_interval_setting;
		next_dma_disable_bit           = dma_disable_bit;
		if (cfg_go) begin
			next_step_interval_setting = pwdata[`CFG_STEP_LSB +: 4];
			next_dma_disable_bit       = pwdata[`CFG_NODMA_BIT];
		end
		if (sense_go) begin
			if (|pend) begin
				next_st0_report = '{interrupt_cause_code: abn_v[sel]
					? `IC_ABNORMAL : `IC_NORMAL, seek_end_flag: 1'b1,
					equipment_check_flag: ec_v[sel], not_ready: 1'b0,
					head: 1'b0, unit: sel};
				next_pcn_report = pcn_v[sel];
			end else if (result_pending) begin
				next_st0_report     = scan_st0;
				next_result_pending = 1'b0;
			end else begin
				next_st0_report = '{interrupt_cause_code: `IC_INVALID,
					seek_end_flag: 1'b0, equipment_check_flag: 1'b0,
					not_ready: 1'b0, head: 1'b0, unit: 2'h0};
			end
		end
		// Drive status answers at once, no execution phase, no interrupt
		if (cmd_go && cmd_op == floppy_control_pkg::CMD_SENSE_DRIVE) begin
			next_drive_status_report = {1'b0, wp_f, 1'b1, tz[cmd_unit],
				1'b1, 1'b0, cmd_unit};
		end
		unique case (scan)
			floppy_control_pkg::SCAN_IDLE: begin
				if (cmd_go && cmd_op == floppy_control_pkg::CMD_READ_ID) begin
					next_scan                      = floppy_control_pkg::SCAN_SEARCH;
					next_scan_unit                 = cmd_unit;
					next_index_seen                = 1'b0;
					next_missing_address_mark_flag = 1'b0;
				end
			end
			floppy_control_pkg::SCAN_SEARCH: begin
				if (id_valid) begin
					next_id_capture     = id_field;
					next_scan_st0       = '{interrupt_cause_code: `IC_NORMAL,
						seek_end_flag: 1'b0, equipment_check_flag: 1'b0,
						not_ready: 1'b0, head: id_field.head[0],
						unit: scan_unit};
					next_result_pending = 1'b1;
					next_scan           = floppy_control_pkg::SCAN_IDLE;
				end else if (index_rise && index_seen) begin
					next_scan_st0 = '{interrupt_cause_code: `IC_ABNORMAL,
						seek_end_flag: 1'b0, equipment_check_flag: 1'b0,
						not_ready: 1'b0, head: 1'b0, unit: scan_unit};
					next_missing_address_mark_flag = 1'b1;
					next_result_pending            = 1'b1;
					next_scan = floppy_control_pkg::SCAN_IDLE;
				end else if (index_rise) begin
					next_index_seen = 1'b1;
				end
			end
		endcase
		// Result phases of the data commands are flagged from outside
		if (result_phase_entered) begin
			next_result_pending = 1'b1;
		end
		if (lp_exit) begin
			next_result_pending = 1'b0;
			next_st0_report     = '0;
			next_pcn_report     = 8'h00;
			next_missing_address_mark_flag = 1'b0;
		end
	end

	// Interrupt holds while any status waits; non-DMA requests add to it
	assign next_irq = |pend | result_pending
		| (dma_disable_bit & data_byte_needed);

	// Read data mux; sampled in the first access cycle
	always_comb begin
		next_prdata  = 32'h0000_0000;
		mapped       = 1'b1;
		unique case (paddr)
			`REG_COMMAND:  next_prdata = 32'h0000_0000;
			`REG_CONFIG:   next_prdata = {27'h0, dma_disable_bit,
				step_interval_setting};
			`REG_RESULT:   next_prdata = {15'h0, missing_address_mark_flag,
				pcn_report, st0_report};
			`REG_ID_FIELD: next_prdata = id_capture;
			`REG_DRIVE:    next_prdata = {24'h0, drive_status_report};
			`REG_STATE:    next_prdata = {24'h0, 4'(pend | moving),
				3'h0, scan == floppy_control_pkg::SCAN_SEARCH};
			default:       mapped = 1'b0;
		endcase
		next_pready  = psel & penable & ~pready;
		next_pslverr = psel & penable & ~pready & ~mapped;
	end

	// Interpreter, bus and pin registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scan                      <= floppy_control_pkg::SCAN_IDLE;
			st0_report                <= '0;
			scan_st0                  <= '0;
			id_capture                <= '0;
			pcn_report                <= 8'h00;
			missing_address_mark_flag <= 1'b0;
			drive_status_report       <= 8'h00;
			index_seen                <= 1'b0;
			scan_unit                 <= 2'h0;
			result_pending            <= 1'b0;
			step_interval_setting     <= `CFG_STEP_RESET;
			dma_disable_bit           <= 1'b0;
			floppy_irq_out            <= 1'b0;
			request_for_master        <= 1'b0;
			transfer_request_out      <= 1'b0;
			prdata                    <= 32'h0000_0000;
			pready                    <= 1'b0;
			pslverr                   <= 1'b0;
		end else begin
			scan                      <= next_scan;
			st0_report                <= next_st0_report;
			scan_st0                  <= next_scan_st0;
			id_capture                <= next_id_capture;
			pcn_report                <= next_pcn_report;
			missing_address_mark_flag <= next_missing_address_mark_flag;
			drive_status_report       <= next_drive_status_report;
			index_seen                <= next_index_seen;
			scan_unit                 <= next_scan_unit;
			result_pending            <= next_result_pending;
			step_interval_setting     <= next_step_interval_setting;
			dma_disable_bit           <= next_dma_disable_bit;
			floppy_irq_out            <= next_irq;
			request_for_master        <= dma_disable_bit & data_byte_needed;
			transfer_request_out      <= ~dma_disable_bit & data_byte_needed;
			prdata                    <= next_prdata;
			pready                    <= next_pready;
			pslverr                   <= next_pslverr;
		end
	end

endmodule

// ---- dv/floppy_control_checker.sv ----
// Port-level assertions for the floppy control command block
`timescale 1ns/1ps
module floppy_control_checker #(parameter int UNITS = 4) (
	input wire logic             clock,
	input wire logic             rst,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             data_byte_needed,
	input wire logic             low_power_state,
	input wire logic [UNITS-1:0] step_out,
	input wire logic             floppy_irq_out,
	input wire logic             transfer_request_out,
	input wire logic             request_for_master
);
	logic       sense_wr;
	logic [3:0] lp_quiet;
	// Cycles since low power was last seen; its exit drops the interrupt
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lp_quiet <= 4'h0;
		end else if (low_power_state) begin
			lp_quiet <= 4'h0;
		end else if (lp_quiet != 4'hf) begin
			lp_quiet <= lp_quiet + 4'h1;
		end
	end
	// Interrupt-status opcode accepted at this edge
	assign sense_wr = psel && penable && pready && pwrite
		&& paddr == 8'h00 && pwdata[3:0] == 4'h4;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	a_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("pready not on second access cycle");
	a_ready_pulse: assert property (pready || pslverr |->
		psel && penable && pready ##1 !pready) else $error("bad pready");
	a_step_width: assert property ($rose(step_out[0]) |=> step_out[0] [*8])
		else $error("step pulse too short");
	a_step_gap: assert property ($fell(step_out[0]) |=> !step_out[0] [*8])
		else $error("step gap too short");
	a_master_req: assert property (request_for_master |->
		floppy_irq_out && $past(data_byte_needed))
		else $error("master request without cause");
	a_dma_req: assert property (transfer_request_out |->
		!request_for_master && $past(data_byte_needed))
		else $error("dma request without cause");
	a_req_rise: assert property ($rose(data_byte_needed) |=>
		request_for_master || transfer_request_out)
		else $error("byte request not signalled");
	// Hold judged when the byte path is quiet, no sense is seen and
	// low power is long past, since its exit clears all pending status
	a_irq_hold: assert property (floppy_irq_out && !sense_wr
		&& !$past(sense_wr) && !$past(data_byte_needed)
		&& lp_quiet == 4'hf |=> floppy_irq_out)
		else $error("interrupt dropped early");
	c_irq_fall: cover property ($fell(floppy_irq_out));
	c_step: cover property ($rose(step_out[0]));
	c_master: cover property (request_for_master);
endmodule
bind floppy_control floppy_control_checker #(.UNITS(UNITS)) mon (
	.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.pslverr, .data_byte_needed, .step_out, .floppy_irq_out,
	.transfer_request_out, .request_for_master, .low_power_state);

// ---- dv/floppy_drive_model.sv ----
// Drive mechanism model: head positions, track-zero sense and index
`timescale 1ns/1ps
module floppy_drive_model (
	input  wire logic       clock,
	input  wire logic [3:0] step_out,
	input  wire logic [3:0] direction_out,
	output logic      [3:0] track_zero_sense,
	output logic            index_pulse_in
);
	int         pos [4] = '{3, 3, 100, 1};
	int         tick = 0;
	logic [3:0] prev = 4'h0;
	// Head moves on each rising step; the mechanical stop holds track 0
	always @(posedge clock) begin
		prev <= step_out;
		tick <= (tick + 1) % 64;
		for (int i = 0; i < 4; i++)
			if (step_out[i] && !prev[i])
				pos[i] <= direction_out[i] ? pos[i] + 1 :
					(pos[i] > 0 ? pos[i] - 1 : 0);
	end
	// Index is four cycles wide so the synchroniser cannot miss it
	always_comb begin
		for (int i = 0; i < 4; i++)
			track_zero_sense[i] = (pos[i] == 0);
		index_pulse_in = (tick < 4);
	end
endmodule

// ---- dv/floppy_control_tb.sv ----
// Self-checking bench for the floppy control command block
`timescale 1ns/1ps
module floppy_control_tb;
	logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
	logic        id_valid, result_phase_entered, data_byte_needed;
	logic        write_protect_in, index_pulse_in, floppy_irq_out;
	logic        low_power_state;
	logic        transfer_request_out, request_for_master;
	logic [7:0]  paddr;
	logic [7:0]  tg [2] = '{8'h05, 8'h02};
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  track_zero_sense, step_out, direction_out;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	floppy_control_pkg::id_field_s id_field;
	floppy_control #(.UNITS(4), .STEP_UNIT_CYCLES(200)) DUT (.clock, .rst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .track_zero_sense, .index_pulse_in, .write_protect_in,
		.low_power_state, .id_valid, .id_field, .result_phase_entered,
		.data_byte_needed, .step_out, .direction_out, .floppy_irq_out,
		.transfer_request_out, .request_for_master);
	floppy_drive_model drv (.clock, .step_out, .direction_out,
		.track_zero_sense, .index_pulse_in);
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////
	// Setup, access, then hold until pready is seen at an edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// No cycle bound; if pready never comes, only the watchdog ends this wait
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Bounded wait: the longest recalibrate needs about 16000 cycles
	task automatic wait_irq();
		for (int n = 0; n < 20000 && floppy_irq_out !== 1'b1; n++)
			@(posedge clock);
		chk("irq", 1, floppy_irq_out);
	endtask
	task automatic sense();
		apb(1, 8'h00, 32'h4);
		apb(0, 8'h08, 0);
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#500us;
		n_mismatch++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, write_protect_in} = 2'b11;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{id_valid, id_field, result_phase_entered, data_byte_needed} = '0;
		low_power_state = 1'b0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		apb(1, 8'h04, 32'h0f);
		apb(0, 8'h04, 0);
		chk("cfg", 32'h0f, rd);
		apb(0, 8'h18, 0);
		chk("unmapped", 32'h0, rd);
		chk("slverr", 32'h1, err);
		apb(1, 8'h00, 32'h02);
		apb(1, 8'h00, 32'h22);
		apb(0, 8'h14, 0);
		chk("overlap", 32'h50, rd);
		wait_irq();
		sense();
		chk("recal", 32'h20, rd);
		chk("cleared", 0, floppy_irq_out);
		for (int i = 0; i < 2; i++) begin
			apb(1, 8'h00, {16'h0, tg[i], 8'h03});
			repeat (5) @(posedge clock);
			chk("dir", i == 0, direction_out[0]);
			wait_irq();
			sense();
			chk("seek", {16'h0, tg[i], 8'h20}, rd);
		end
		wait_irq();
		sense();
		chk("recal fail", 32'h72, rd[7:0]);
		chk("steps", 21, drv.pos[2]);
		apb(1, 8'h00, 32'h01);
		wait_irq();
		sense();
		chk("no mark", 3'b101, {rd[16], rd[7:6]});
		apb(1, 8'h00, 32'h01);
		id_field <= 32'h05011202;
		id_valid <= 1'b1;
		@(posedge clock);
		id_valid <= 1'b0;
		wait_irq();
		apb(0, 8'h0c, 0);
		chk("id", 32'h05011202, rd);
		sense();
		apb(1, 8'h00, 32'h05);
		apb(0, 8'h10, 0);
		chk("drive", 32'h68, rd);
		chk("quiet", 0, floppy_irq_out);
		for (int m = 1; m >= 0; m--) begin
			apb(1, 8'h04, {27'h0, m[0], 4'hf});
			data_byte_needed <= 1'b1;
			repeat (3) @(posedge clock);
			chk("mode", {m[0], !m[0], m[0]}, {request_for_master,
				transfer_request_out, floppy_irq_out});
			data_byte_needed <= 1'b0;
		end
		repeat (3) @(posedge clock);
		result_phase_entered <= 1'b1;
		@(posedge clock);
		result_phase_entered <= 1'b0;
		wait_irq();
		sense();
		chk("irq off", 0, floppy_irq_out);
		// Leave a drive pending, then pass through low power unsensed
		apb(1, 8'h00, 32'h0103);
		wait_irq();
		low_power_state <= 1'b1;
		repeat (8) @(posedge clock);
		low_power_state <= 1'b0;
		repeat (8) @(posedge clock);
		chk("lp irq", 0, floppy_irq_out);
		apb(0, 8'h08, 0);
		chk("lp result", 0, rd);
		// Cylinder now counts from zero, so the same target steps inward
		apb(1, 8'h00, 32'h0103);
		repeat (5) @(posedge clock);
		chk("lp dir", 1, direction_out[0]);
		wait_irq();
		sense();
		chk("lp seek", 32'h0120, rd);
		sense();
		chk("no cause", 32'h80, rd[7:0]);
		wrap_up();
	end
endmodule
